// File: srcfmt_pkg.sv
package srcfmt_pkg;
  // ----------------------------------------
  // Timing and picture clock
  // ----------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int RATE_BASE = 1800000;
  localparam logic [6:0] DEF_DIV = 7'h3c;
  localparam logic [6:0] DIV_MAX = 7'h7f;
  localparam logic [9:0] CONV_LO = 10'h3e8;
  localparam logic [9:0] CONV_HI = 10'h3e9;
  // ----------------------------------------
  // Picture sizes
  // ----------------------------------------
  localparam logic [11:0] DIM_MIN = 12'h004;
  localparam logic [11:0] HEIGHT_MAX = 12'h480;
  localparam logic [11:0] WIDTH_MAX = 12'h800;
  localparam logic [11:0] ALIGN_MASK = 12'h00f;
  localparam logic [2:0] FMT_SMALLEST = 3'h1;
  localparam logic [2:0] FMT_QUARTER = 3'h2;
  localparam logic [2:0] FMT_COMMON = 3'h3;
  localparam logic [2:0] FMT_FOUR = 3'h4;
  localparam logic [2:0] FMT_SIXTEEN = 3'h5;
  // ----------------------------------------
  // Pixel aspect codes
  // ----------------------------------------
  localparam logic [2:0] PAR_SQUARE = 3'h1;
  localparam logic [2:0] PAR_12_11 = 3'h2;
  localparam logic [2:0] PAR_10_11 = 3'h3;
  localparam logic [2:0] PAR_16_11 = 3'h4;
  localparam logic [2:0] PAR_40_33 = 3'h5;
  localparam logic [2:0] PAR_FREE = 3'h7;
  // ----------------------------------------
  // Sample levels
  // ----------------------------------------
  localparam logic [7:0] LVL_BLACK = 8'h10;
  localparam logic [7:0] LVL_WHITE = 8'heb;
  localparam logic [7:0] LVL_ZERO_C = 8'h80;
  localparam logic [7:0] LVL_PEAK_C = 8'hf0;
  localparam logic [7:0] SAMPLE_LO = 8'h01;
  localparam logic [7:0] SAMPLE_HI = 8'hfe;
  // ----------------------------------------
  // Register offsets and fields
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SIZE = 8'h04;
  localparam logic [7:0] REG_CLOCK = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_PAD = 8'h10;
  localparam logic [7:0] REG_CHROMA = 8'h14;
  localparam logic [7:0] REG_LEVELS = 8'h18;
  localparam logic [7:0] REG_IRQ_STAT = 8'h1c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] REG_FREE_PAR = 8'h24;
  localparam int CTRL_START = 0;
  localparam int CTRL_CUST_FMT = 1;
  localparam int CTRL_CUST_CLK = 2;
  localparam int CTRL_CONV1001 = 3;
  localparam int CTRL_BIDIR = 4;
  localparam int CTRL_SLICE = 5;
  localparam int CTRL_FMT_LSB = 8;
  localparam int CTRL_PAR_LSB = 12;
  localparam logic [15:0] CTRL_RESET = 16'h0200;
  localparam int IRQ_PIC = 0;
  localparam int IRQ_REFRESH = 1;
  localparam int IRQ_CFG = 2;
  localparam int IRQ_W = 3;
endpackage : srcfmt_pkg

// File: srcfmt_link_if.sv
interface srcfmt_link_if;
  logic refresh_cmd;
  logic [4:0] refresh_rows;
  logic nonempty_only;
  logic [7:0] min_skip;
  logic par_agreed;
  logic clk_agreed;
  logic src_tick;
  logic pic_valid;
  logic pic_bidir_b;
  logic [4:0] pic_self_contained_coding_rows;
  logic [11:0] luma_width;
  logic [11:0] luma_height;
  logic [6:0] clk_divisor;
  logic clk_conv1001;

  modport coder (
    input refresh_cmd, refresh_rows, nonempty_only, min_skip, par_agreed, clk_agreed,
    output src_tick, pic_valid, pic_bidir_b, pic_self_contained_coding_rows, luma_width, luma_height,
    output clk_divisor, clk_conv1001
  );
  modport remote (
    output refresh_cmd, refresh_rows, nonempty_only, min_skip, par_agreed, clk_agreed,
    input src_tick, pic_valid, pic_bidir_b, pic_self_contained_coding_rows, luma_width, luma_height,
    input clk_divisor, clk_conv1001
  );
endinterface : srcfmt_link_if

// File: srcfmt_remote.sv
module srcfmt_remote (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  srcfmt_link_if.remote LINK,
  input wire logic REFRESH_REQ_IN,
  input wire logic [4:0] REFRESH_ROWS_IN,
  input wire logic NONEMPTY_ONLY_IN,
  input wire logic [7:0] MIN_SKIP_IN,
  input wire logic PAR_AGREE_IN,
  input wire logic CLK_AGREE_IN,
  output logic [15:0] PIC_COUNT_OUT,
  output logic SPACING_ERR_OUT,
  output logic FORMAT_ERR_OUT
);
  import srcfmt_pkg::*;

  typedef struct packed {
    logic refresh_cmd;
    logic [4:0] refresh_rows;
    logic nonempty_only;
    logic [7:0] min_skip;
    logic par_agreed;
    logic clk_agreed;
    logic seen;
    logic [7:0] gap;
    logic [15:0] pics;
    logic spacing_err;
    logic format_err;
  } remote_state_type;

  remote_state_type state;
  remote_state_type next_state;
  logic dims_bad;
  logic clk_bad;

  // ----------------------------------------
  // Checks on what the coder sends
  // ----------------------------------------
  always_comb begin
    // [RULE7] height range check
    dims_bad = (LINK.luma_height < DIM_MIN) || (LINK.luma_height > HEIGHT_MAX) ||
               (LINK.luma_height[1:0] != 2'h0);
    // [RULE8] width range check
    dims_bad = dims_bad || (LINK.luma_width < DIM_MIN) || (LINK.luma_width > WIDTH_MAX) ||
               (LINK.luma_width[1:0] != 2'h0);
    // [RULE2] divisor range check
    clk_bad = (LINK.clk_divisor == 7'h00) ||
              (!state.clk_agreed && (LINK.clk_divisor != DEF_DIV || !LINK.clk_conv1001));
  end

  always_comb begin
    next_state = state;
    // [RULE17] refresh command pulse
    next_state.refresh_cmd = REFRESH_REQ_IN;
    next_state.refresh_rows = REFRESH_ROWS_IN;
    // [RULE18] non-empty header command
    next_state.nonempty_only = NONEMPTY_ONLY_IN;
    next_state.min_skip = MIN_SKIP_IN;
    // [RULE11] aspect agreement
    next_state.par_agreed = PAR_AGREE_IN;
    next_state.clk_agreed = CLK_AGREE_IN;
    if (LINK.src_tick) begin
      if (LINK.pic_valid) begin
        // [RULE15] spacing between pictures
        if (state.seen && state.gap < state.min_skip) next_state.spacing_err = 1'b1;
        next_state.gap = 8'h00;
        next_state.seen = 1'b1;
        next_state.pics = state.pics + 16'h0001;
        if (dims_bad || clk_bad) next_state.format_err = 1'b1;
      end else if (state.gap != 8'hff) begin
        next_state.gap = state.gap + 8'h01;
      end
    end
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign LINK.refresh_cmd = state.refresh_cmd;
  assign LINK.refresh_rows = state.refresh_rows;
  assign LINK.nonempty_only = state.nonempty_only;
  assign LINK.min_skip = state.min_skip;
  assign LINK.par_agreed = state.par_agreed;
  assign LINK.clk_agreed = state.clk_agreed;
  assign PIC_COUNT_OUT = state.pics;
  assign SPACING_ERR_OUT = state.spacing_err;
  assign FORMAT_ERR_OUT = state.format_err;
endmodule : srcfmt_remote

// File: srcfmt_coder.sv
// Function
// [RULE1] Default progressive rate is 30000/1001 Hz
// [RULE2] Custom rate 1800000 over divisor times factor
// [RULE3] Samples 1 to 254 pass correctly
// [RULE4] Nominal black, white, colour levels known
// [RULE5] Chroma planes half width, half height
// [RULE6] Five standard luma sizes fixed
// [RULE7] Custom height multiple of four, 4..1152
// [RULE8] Custom width multiple of four, 4..2048
// [RULE9] Pad to multiple of 16, crop display
// [RULE10] Standard formats use 12:11 aspect
// [RULE11] Custom aspect codes need prior agreement
// [RULE12] Default rate always supported, custom optional
// [RULE13] Decoder supports smallest and quarter formats
// [RULE14] Encoder supports smallest or quarter format
// [RULE15] Skip agreed minimum pictures between sends
// [RULE16] Bidirectional pair counts as two pictures
// [RULE17] Refresh command makes rows self-contained
// [RULE18] Suppress empty headers when commanded, no slices
// [RULE19] Bad configuration flagged, start refused
module srcfmt_coder #(
  parameter int RATE_STEP = srcfmt_pkg::RATE_BASE
) (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  srcfmt_link_if.coder LINK,
  input wire logic [7:0] PIX_IN,
  output logic [7:0] PIX_OUT,
  input wire logic [11:0] DISP_X_IN,
  input wire logic [11:0] DISP_Y_IN,
  output logic DISP_KEEP_OUT,
  output logic SUPPRESS_EMPTY_OUT,
  output logic COARSE_Q_OUT
);
  import srcfmt_pkg::*;

  typedef enum logic {ST_IDLE, ST_RUN} run_type;

  typedef struct packed {
    run_type run;
    logic [15:0] ctrl;
    logic [11:0] cust_w;
    logic [11:0] cust_h;
    logic [6:0] div;
    logic [7:0] par_m;
    logic [7:0] par_n;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_stat;
    logic cfg_err;
    logic [47:0] acc;
    logic [7:0] skip_cnt;
    logic pair_b;
    logic refresh_pend;
    logic [4:0] refresh_rows;
    logic tick;
    logic pic_valid;
    logic pic_b;
    logic [4:0] pic_rows;
    logic coarse_q;
    logic [31:0] prdata;
    logic pslverr;
    logic [7:0] pix;
    logic keep;
  } coder_state_type;

  coder_state_type state;
  coder_state_type next_state;
  logic [11:0] width;
  logic [11:0] height;
  logic [11:0] pad_w;
  logic [11:0] pad_h;
  logic [2:0] fmt;
  logic [2:0] par;
  logic fmt_ok;
  logic bad;
  logic [6:0] div_eff;
  logic [9:0] conv_eff;
  logic [47:0] period;
  logic [47:0] acc_sum;
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd;
  logic [IRQ_W-1:0] events;
  logic send;

  // ----------------------------------------
  // Picture format and checks
  // ----------------------------------------
  always_comb begin
    fmt = state.ctrl[CTRL_FMT_LSB +: 3];
    par = state.ctrl[CTRL_PAR_LSB +: 3];
    fmt_ok = 1'b1;
    // [RULE6] standard luma sizes
    case (fmt)
      FMT_SMALLEST: {width, height} = {12'h080, 12'h060};
      FMT_QUARTER: {width, height} = {12'h0b0, 12'h090};
      FMT_COMMON: {width, height} = {12'h160, 12'h120};
      FMT_FOUR: {width, height} = {12'h2c0, 12'h240};
      FMT_SIXTEEN: {width, height} = {12'h580, 12'h480};
      default: {width, height, fmt_ok} = {12'h080, 12'h060, 1'b0};
    endcase
    if (state.ctrl[CTRL_CUST_FMT]) {width, height, fmt_ok} = {state.cust_w, state.cust_h, 1'b1};
    // [RULE9] next multiple of 16
    pad_w = (width + ALIGN_MASK) & ~ALIGN_MASK;
    pad_h = (height + ALIGN_MASK) & ~ALIGN_MASK;
    // [RULE19] configuration error
    bad = !fmt_ok;
    if (state.ctrl[CTRL_CUST_FMT]) begin
      // [RULE7] custom height limits
      bad = bad || (height < DIM_MIN) || (height > HEIGHT_MAX) || (height[1:0] != 2'h0);
      // [RULE8] custom width limits
      bad = bad || (width < DIM_MIN) || (width > WIDTH_MAX) || (width[1:0] != 2'h0);
      // [RULE11] aspect only after agreement
      if (par != PAR_12_11)
        bad = bad || !LINK.par_agreed ||
              !(par inside {PAR_SQUARE, PAR_10_11, PAR_16_11, PAR_40_33, PAR_FREE});
      if (par == PAR_FREE)
        bad = bad || state.par_m == 8'h00 || state.par_n == 8'h00 ||
              (!state.par_m[0] && !state.par_n[0]);
    end else begin
      // [RULE10] standard uses 12:11
      bad = bad || (par != PAR_12_11);
    end
    // [RULE2] custom clock limits
    if (state.ctrl[CTRL_CUST_CLK]) bad = bad || !LINK.clk_agreed || state.div == 7'h00 || state.div > DIV_MAX;
  end

  // ----------------------------------------
  // Picture clock
  // ----------------------------------------
  always_comb begin
    // [RULE1] default 30000/1001 rate
    div_eff = DEF_DIV;
    conv_eff = CONV_HI;
    // [RULE12] custom rate optional
    if (state.ctrl[CTRL_CUST_CLK]) begin
      div_eff = state.div;
      conv_eff = state.ctrl[CTRL_CONV1001] ? CONV_HI : CONV_LO;
    end
    // [RULE2] period in rate-step units
    period = 48'(div_eff) * 48'(conv_eff) * 48'(CLK_HZ);
    acc_sum = state.acc + 48'(RATE_STEP);
  end

  // ----------------------------------------
  // Register bus decode
  // ----------------------------------------
  assign setup = PSEL_IN && !PENABLE_IN;
  assign access = PSEL_IN && PENABLE_IN;

  always_comb begin
    mapped = 1'b1;
    rd = 32'h0000_0000;
    case (PADDR_IN)
      REG_CTRL: rd = 32'(state.ctrl);
      REG_SIZE: rd = {4'h0, state.cust_h, 4'h0, state.cust_w};
      REG_CLOCK: rd = 32'(state.div);
      REG_STATUS: rd = {16'h0000, state.skip_cnt, 4'h0, state.refresh_pend,
                        SUPPRESS_EMPTY_OUT, state.cfg_err, state.run == ST_RUN};
      REG_PAD: rd = {4'h0, pad_h, 4'h0, pad_w};
      // [RULE5] chroma half size
      REG_CHROMA: rd = {5'h00, pad_h[11:1], 5'h00, pad_w[11:1]};
      // [RULE4] nominal levels
      REG_LEVELS: rd = {LVL_PEAK_C, LVL_ZERO_C, LVL_WHITE, LVL_BLACK};
      REG_IRQ_STAT: rd = 32'(state.irq_stat);
      REG_IRQ_MASK: rd = 32'(state.irq_mask);
      REG_FREE_PAR: rd = {16'h0000, state.par_n, state.par_m};
      default: mapped = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    events = '0;
    send = 1'b0;
    next_state.cfg_err = bad;
    if (setup) begin
      next_state.prdata = PWRITE_IN ? 32'h0000_0000 : rd;
      next_state.pslverr = !mapped;
    end
    if (access && PWRITE_IN) begin
      case (PADDR_IN)
        REG_CTRL: next_state.ctrl = PWDATA_IN[15:0];
        REG_SIZE: {next_state.cust_h, next_state.cust_w} = {PWDATA_IN[27:16], PWDATA_IN[11:0]};
        REG_CLOCK: next_state.div = PWDATA_IN[6:0];
        REG_IRQ_MASK: next_state.irq_mask = PWDATA_IN[IRQ_W-1:0];
        REG_FREE_PAR: {next_state.par_n, next_state.par_m} = PWDATA_IN[15:0];
        default: ;
      endcase
    end
    // [RULE19] start refused on error
    case (state.run)
      ST_IDLE: begin
        next_state.acc = 48'h0;
        next_state.skip_cnt = 8'hff;
        next_state.pair_b = 1'b0;
        events[IRQ_CFG] = state.ctrl[CTRL_START] && bad;
        if (state.ctrl[CTRL_START] && !bad) next_state.run = ST_RUN;
      end
      ST_RUN: if (!state.ctrl[CTRL_START] || bad) next_state.run = ST_IDLE;
      default: next_state.run = ST_IDLE;
    endcase
    next_state.tick = 1'b0;
    next_state.pic_valid = 1'b0;
    if (state.run == ST_RUN) begin
      next_state.acc = acc_sum;
      if (acc_sum >= period) begin
        // Drop backlog when period shrinks
        next_state.acc = (acc_sum - period >= period) ? 48'h0 : acc_sum - period;
        next_state.tick = 1'b1;
        // [RULE15] enforce minimum skip
        send = state.skip_cnt >= LINK.min_skip;
        next_state.skip_cnt = send ? 8'h00 :
                              (state.skip_cnt == 8'hff ? 8'hff : state.skip_cnt + 8'h01);
      end
    end
    if (send) begin
      next_state.pic_valid = 1'b1;
      // [RULE16] pair halves counted apart
      next_state.pic_b = state.ctrl[CTRL_BIDIR] && !state.pair_b;
      next_state.pair_b = next_state.pic_b;
      // [RULE17] self-contained rows, coarse q
      next_state.pic_rows = state.refresh_pend ? state.refresh_rows : 5'h00;
      next_state.coarse_q = state.refresh_pend;
      next_state.refresh_pend = 1'b0;
      events[IRQ_PIC] = 1'b1;
    end
    // [RULE17] latch refresh command
    if (LINK.refresh_cmd) begin
      next_state.refresh_pend = 1'b1;
      next_state.refresh_rows = (LINK.refresh_rows == 5'h00) ? 5'h01 : LINK.refresh_rows;
      events[IRQ_REFRESH] = 1'b1;
    end
    next_state.irq_stat = ((access && !PWRITE_IN && PADDR_IN == REG_IRQ_STAT) ? '0 : state.irq_stat) | events;
    // [RULE3] clamp samples to 1..254
    next_state.pix = (PIX_IN < SAMPLE_LO) ? SAMPLE_LO : ((PIX_IN > SAMPLE_HI) ? SAMPLE_HI : PIX_IN);
    // [RULE9] crop padded area on display
    next_state.keep = (DISP_X_IN < width) && (DISP_Y_IN < height);
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state <= '0;
      state.ctrl <= CTRL_RESET;
      state.skip_cnt <= 8'hff;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PRDATA_OUT = state.prdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = state.pslverr && access;
  assign IRQ_OUT = |(state.irq_stat & state.irq_mask);
  // [RULE18] suppress empty headers
  assign SUPPRESS_EMPTY_OUT = LINK.nonempty_only && !state.ctrl[CTRL_SLICE];
  assign COARSE_Q_OUT = state.coarse_q;
  assign PIX_OUT = state.pix;
  assign DISP_KEEP_OUT = state.keep;
  assign LINK.src_tick = state.tick;
  assign LINK.pic_valid = state.pic_valid;
  assign LINK.pic_bidir_b = state.pic_b;
  assign LINK.pic_self_contained_coding_rows = state.pic_rows;
  // [RULE13] sizes sent to decoder
  assign LINK.luma_width = width;
  assign LINK.luma_height = height;
  assign LINK.clk_divisor = div_eff;
  assign LINK.clk_conv1001 = conv_eff == CONV_HI;
  // [RULE14] quarter format is reset choice
endmodule : srcfmt_coder

// File: video_source_format_control_checker.sv
module srcfmt_link_checker
  import srcfmt_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic refresh_cmd,
  input wire logic [4:0] refresh_rows,
  input wire logic [7:0] min_skip,
  input wire logic clk_agreed,
  input wire logic src_tick,
  input wire logic pic_valid,
  input wire logic pic_bidir_b,
  input wire logic [4:0] pic_self_contained_coding_rows,
  input wire logic [11:0] luma_width,
  input wire logic [11:0] luma_height,
  input wire logic [6:0] clk_divisor,
  input wire logic clk_conv1001
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic [7:0] skips;
  logic seen;
  logic last_b;
  logic [4:0] pend;
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      skips <= 8'h00;
      seen <= 1'b0;
      last_b <= 1'b0;
      pend <= 5'h00;
    end else begin
      if (pic_valid) begin
        skips <= 8'h00;
        seen <= 1'b1;
        last_b <= pic_bidir_b;
      end else if (src_tick) begin
        skips <= skips + 8'h01;
      end
      if (refresh_cmd) begin
        pend <= (refresh_rows == 5'h00) ? 5'h01 : refresh_rows;
      end else if (pic_valid) begin
        pend <= 5'h00;
      end
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_pic;
    pic_valid && src_tick;
  endsequence
  property p_valid_on_tick;
    pic_valid |-> src_tick;
  endproperty
  a_valid_on_tick: assert property (p_valid_on_tick) else $error("picture sent off a tick");
  property p_tick_pulse;
    src_tick |=> !src_tick [*8];
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("ticks too close");
  property p_skip;
    s_pic |-> !seen || skips == min_skip;
  endproperty
  a_skip: assert property (p_skip) else $error("wrong skip count");
  property p_refresh;
    s_pic |-> pic_self_contained_coding_rows == pend;
  endproperty
  a_refresh: assert property (p_refresh) else $error("refresh rows wrong");
  property p_width;
    pic_valid |-> luma_width >= DIM_MIN && luma_width <= WIDTH_MAX && luma_width[1:0] == 2'b00;
  endproperty
  a_width: assert property (p_width) else $error("bad width sent");
  property p_height;
    pic_valid |-> luma_height >= DIM_MIN && luma_height <= HEIGHT_MAX && luma_height[1:0] == 2'b00;
  endproperty
  a_height: assert property (p_height) else $error("bad height sent");
  property p_clock;
    pic_valid |-> clk_divisor != 7'h00 && (clk_agreed || (clk_divisor == DEF_DIV && clk_conv1001));
  endproperty
  a_clock: assert property (p_clock) else $error("bad picture clock");
  property p_hold;
    !pic_valid |-> $stable(pic_self_contained_coding_rows) && $stable(pic_bidir_b);
  endproperty
  a_hold: assert property (p_hold) else $error("picture tags moved");
  property p_pair;
    pic_valid && last_b |-> !pic_bidir_b;
  endproperty
  a_pair: assert property (p_pair) else $error("two B halves in a row");
endmodule : srcfmt_link_checker

// File: video_source_format_control_tb_top.sv
module video_source_format_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import srcfmt_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, keep, supp, coarse;
  logic ref_req, nonempty, par_ag, clk_ag, spacing_err, format_err;
  logic [7:0] paddr, pix_in, pix_out, min_skip;
  logic [31:0] pwdata, prdata;
  logic [11:0] disp_x, disp_y;
  logic [4:0] ref_rows;
  logic [15:0] pic_count;
  logic [11:0] stdw [5] = '{12'h080, 12'h0b0, 12'h160, 12'h2c0, 12'h580};
  logic [11:0] stdh [5] = '{12'h060, 12'h090, 12'h120, 12'h240, 12'h480};
  logic b;
  int mismatches, cmp_count, g;
  srcfmt_link_if link();
  srcfmt_coder #(.RATE_STEP(900000000)) u_srcfmt_coder (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .LINK(link), .PIX_IN(pix_in), .PIX_OUT(pix_out),
    .DISP_X_IN(disp_x), .DISP_Y_IN(disp_y), .DISP_KEEP_OUT(keep), .SUPPRESS_EMPTY_OUT(supp), .COARSE_Q_OUT(coarse));
  srcfmt_remote u_srcfmt_remote (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .LINK(link), .REFRESH_REQ_IN(ref_req),
    .REFRESH_ROWS_IN(ref_rows), .NONEMPTY_ONLY_IN(nonempty), .MIN_SKIP_IN(min_skip), .PAR_AGREE_IN(par_ag),
    .CLK_AGREE_IN(clk_ag), .PIC_COUNT_OUT(pic_count), .SPACING_ERR_OUT(spacing_err), .FORMAT_ERR_OUT(format_err));
  srcfmt_link_checker u_srcfmt_link_checker (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .refresh_cmd(link.refresh_cmd),
    .refresh_rows(link.refresh_rows), .min_skip(link.min_skip), .clk_agreed(link.clk_agreed),
    .src_tick(link.src_tick), .pic_valid(link.pic_valid), .pic_bidir_b(link.pic_bidir_b),
    .pic_self_contained_coding_rows(link.pic_self_contained_coding_rows), .luma_width(link.luma_width), .luma_height(link.luma_height),
    .clk_divisor(link.clk_divisor), .clk_conv1001(link.clk_conv1001));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    check({31'h0, pslverr}, {31'h0, a > REG_FREE_PAR});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    apb(1'b0, a, 32'h0, r);
    check(r & m, e);
  endtask : rdc
  function automatic logic [31:0] ctl(input logic [2:0] f, input logic [2:0] p, input logic [7:0] fl);
    return {16'h0, 1'b0, p, 1'b0, f, fl};
  endfunction : ctl
  task automatic cfg(input logic [31:0] c, input logic [31:0] sz, input logic [6:0] dv, input logic pa,
                     input logic ca, input logic e);
    par_ag <= pa;
    clk_ag <= ca;
    wr(REG_SIZE, sz);
    wr(REG_CLOCK, {25'h0, dv});
    wr(REG_CTRL, c);
    rdc(REG_STATUS, 32'h3, {30'h0, e, c[0] & ~e});
  endtask : cfg
  task automatic cc(input logic [31:0] sz, input logic e);
    cfg(ctl(3'h2, 3'h2, 8'h02), sz, 7'h0, 1'b0, 1'b0, e);
  endtask : cc
  task automatic io(input logic [11:0] x, input logic [11:0] y, input logic [7:0] p, input logic k,
                    input logic [7:0] q);
    @(posedge clk);
    disp_x <= x;
    disp_y <= y;
    pix_in <= p;
    @(posedge clk);
    #1;
    check({31'h0, keep}, {31'h0, k});
    check({24'h0, pix_out}, {24'h0, q});
  endtask : io
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic pulse(input logic [4:0] r);
    @(posedge clk);
    ref_req <= 1'b1;
    ref_rows <= r;
    @(posedge clk);
    ref_req <= 1'b0;
  endtask : pulse
  task automatic wait_pic();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (link.pic_valid !== 1'b1 && n < 9000);
    check({31'h0, link.pic_valid}, 32'h1);
  endtask : wait_pic
  task automatic gap(output int n);
    n = 0;
    do @(posedge clk); while (link.src_tick !== 1'b1);
    do begin
      @(posedge clk);
      n++;
    end while (link.src_tick !== 1'b1 && n < 2000);
  endtask : gap
  // ----------------------------------------
  // Clock, reset and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    summarize();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, ref_req, nonempty, par_ag, clk_ag, paddr, pix_in, min_skip, pwdata, disp_x, disp_y, ref_rows} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(REG_CTRL, 32'hffffffff, {16'h0, CTRL_RESET});
    rdc(REG_LEVELS, 32'hffffffff, 32'hf080eb10);
    rdc(8'h28, 32'hffffffff, 32'h0);
    rdc(REG_STATUS, 32'h2, 32'h2);
    for (int i = 0; i < 5; i++) begin
      wr(REG_CTRL, ctl(3'(i + 1), 3'h2, 8'h00));
      rdc(REG_PAD, 32'h0fff0fff, {4'h0, stdh[i], 4'h0, stdw[i]});
      rdc(REG_CHROMA, 32'h0fff0fff, {5'h0, stdh[i][11:1], 5'h0, stdw[i][11:1]});
      check({20'h0, link.luma_width}, {20'h0, stdw[i]});
      check({20'h0, link.luma_height}, {20'h0, stdh[i]});
    end
    cfg(ctl(3'h2, 3'h1, 8'h00), 32'h0, 7'h0, 1'b0, 1'b0, 1'b1);
    cc(32'h00240064, 1'b0);
    rdc(REG_PAD, 32'h0fff0fff, 32'h00300070);
    rdc(REG_CHROMA, 32'h0fff0fff, 32'h00180038);
    io(12'h063, 12'h023, 8'h00, 1'b1, 8'h01);
    io(12'h064, 12'h000, 8'hff, 1'b0, 8'hfe);
    io(12'h000, 12'h024, 8'h80, 1'b0, 8'h80);
    cc(32'h00240066, 1'b1);
    cc(32'h00240804, 1'b1);
    cc(32'h04800800, 1'b0);
    cc(32'h04840004, 1'b1);
    cc(32'h00040004, 1'b0);
    cc(32'h00060004, 1'b1);
    cfg(ctl(3'h2, 3'h1, 8'h02), 32'h00240064, 7'h0, 1'b0, 1'b0, 1'b1);
    cfg(ctl(3'h2, 3'h1, 8'h02), 32'h00240064, 7'h0, 1'b1, 1'b0, 1'b0);
    wr(REG_FREE_PAR, 32'h00000204);
    cfg(ctl(3'h2, 3'h7, 8'h02), 32'h00240064, 7'h0, 1'b1, 1'b0, 1'b1);
    wr(REG_FREE_PAR, 32'h00000304);
    cfg(ctl(3'h2, 3'h7, 8'h02), 32'h00240064, 7'h0, 1'b1, 1'b0, 1'b0);
    cfg(ctl(3'h2, 3'h2, 8'h04), 32'h0, 7'h00, 1'b0, 1'b1, 1'b1);
    cfg(ctl(3'h2, 3'h2, 8'h0c), 32'h0, 7'h7f, 1'b0, 1'b1, 1'b0);
    cfg(ctl(3'h2, 3'h2, 8'h0c), 32'h0, 7'h7f, 1'b0, 1'b0, 1'b1);
    cfg(ctl(3'h2, 3'h2, 8'h0d), 32'h0, 7'h00, 1'b0, 1'b1, 1'b1);
    rdc(REG_IRQ_STAT, 32'h4, 32'h4);
    nonempty <= 1'b1;
    wr(REG_CTRL, ctl(3'h2, 3'h2, 8'h00));
    rdc(REG_STATUS, 32'h4, 32'h4);
    check({31'h0, supp}, 32'h1);
    wr(REG_CTRL, ctl(3'h2, 3'h2, 8'h20));
    rdc(REG_STATUS, 32'h4, 32'h0);
    check({31'h0, supp}, 32'h0);
    rst <= 1'b1;
    {par_ag, clk_ag} <= 2'b00;
    min_skip <= 8'h02;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wr(REG_IRQ_MASK, 32'h1);
    wr(REG_CTRL, ctl(3'h1, 3'h2, 8'h01));
    gap(g);
    check({31'h0, g inside {[667:668]}}, 32'h1);
    pulse(5'h03);
    wait_pic();
    check({27'h0, link.pic_self_contained_coding_rows}, 32'h3);
    settle();
    check({30'h0, coarse, irq}, 32'h3);
    rdc(REG_IRQ_STAT, 32'h7, 32'h3);
    settle();
    check({31'h0, irq}, 32'h0);
    pulse(5'h00);
    wait_pic();
    check({27'h0, link.pic_self_contained_coding_rows}, 32'h1);
    wait_pic();
    check({27'h0, link.pic_self_contained_coding_rows}, 32'h0);
    settle();
    check({31'h0, coarse}, 32'h0);
    wr(REG_IRQ_MASK, 32'h0);
    rdc(REG_IRQ_STAT, 32'h0, 32'h0);
    wait_pic();
    settle();
    check({31'h0, irq}, 32'h0);
    rdc(REG_IRQ_STAT, 32'h1, 32'h1);
    wr(REG_CTRL, ctl(3'h1, 3'h2, 8'h11));
    wait_pic();
    b = link.pic_bidir_b;
    wait_pic();
    check({31'h0, link.pic_bidir_b}, {31'h0, ~b});
    settle();
    check({pic_count, 14'h0, spacing_err, format_err}, {16'h7, 16'h0});
    clk_ag <= 1'b1;
    wr(REG_CLOCK, 32'h1);
    wr(REG_CTRL, ctl(3'h1, 3'h2, 8'h05));
    gap(g);
    gap(g);
    check({31'h0, g inside {[11:12]}}, 32'h1);
    summarize();
  end
endmodule : video_source_format_control_tb_top
